// File: hpp_device.sv
// display controller end: decodes host cycles, stretches them with wait
// Function
// - reset only after 256 low cycles
// - straps choose the host interface type
// - 8080 read strobe low marks read
// - 6800 enable high qualifies the access
// - 8080 write strobe low marks write
// - 6800 direction high means read
// - 6800 direction low means write
// - select low: status read, command write
// - select high: data read or write
// - busy pulls wait low; host holds off
// - serial mode: control pins become inputs
// - strap codes 00x,01x,100,101,11x
// - register 01h bit0 picks bus width
`timescale 1ns/100ps
`include "hpp_cfg.svh"
module hpp_device #(
  parameter int RESET_HOLD = `HPP_RESET_HOLD_CYCLES,
  parameter int BUSY_CYCLES = `HPP_BUSY_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // bus
  hpp_bus_if.dev bus,
  // controller side
  input wire logic [15:0] rd_data_in,
  input wire logic [15:0] status_in,
  output logic wr_valid_out,
  output logic wr_is_data_out,
  output logic [15:0] wr_data_out,
  output logic rd_valid_out,
  output logic ctrl_reset_out,
  output logic wide_bus_out,
  output hpp_pkg::hpp_mode_t mode_out,
  output logic [3:0] aux_input_pins_out
);
  typedef enum logic [1:0] {DS_IDLE, DS_BUSY, DS_DONE} hpp_dst_t;
  hpp_dst_t state_ff;
  logic [`HPP_RESET_CNT_W:0] rlow_ff;
  logic [`HPP_BUSY_CNT_W:0] busy_ff;
  logic [15:0] cmd_ff;
  logic cyc_read_ff;
  logic cyc_data_ff;
  logic wait_n_ff;
  logic parallel;
  logic active;
  logic is_read;
  logic [15:0] rd_word;

  // strap decode is continuous so the mode follows the pins
  assign mode_out = hpp_pkg::hpp_decode(bus.host_port_select);
  assign parallel = (mode_out == hpp_pkg::HPP_MODE_8080) || (mode_out == hpp_pkg::HPP_MODE_6800);
  assign is_read = (mode_out == hpp_pkg::HPP_MODE_6800) ? bus.wr_pin : !bus.rd_pin;
  // access in progress; chip select high masks it
  assign active = parallel && !bus.cs_n && ((mode_out == hpp_pkg::HPP_MODE_6800) ? bus.rd_pin
                  : (!bus.rd_pin || !bus.wr_pin));
  assign bus.wait_n = wait_n_ff;
  assign rd_word = cyc_data_ff ? rd_data_in : (status_in | `HPP_STATUS_VALUE);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rlow_ff <= '0;
      ctrl_reset_out <= 1'b1;
    end else begin
      // short low pulses are filtered out
      if (bus.reset_in_n) begin
        rlow_ff <= '0;
        ctrl_reset_out <= 1'b0;
      end else if (rlow_ff == (`HPP_RESET_CNT_W+1)'(RESET_HOLD - 1)) begin
        ctrl_reset_out <= 1'b1;
      end else begin
        rlow_ff <= rlow_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || ctrl_reset_out) begin
      state_ff <= DS_IDLE;
      busy_ff <= '0;
      wait_n_ff <= 1'b1;
      cyc_read_ff <= 1'b0;
      cyc_data_ff <= 1'b0;
    end else begin
      case (state_ff)
        DS_IDLE: begin
          if (active) begin
            cyc_read_ff <= is_read;
            cyc_data_ff <= bus.cmd_data_select;
            busy_ff <= (`HPP_BUSY_CNT_W+1)'(BUSY_CYCLES);
            wait_n_ff <= 1'b0;
            state_ff <= DS_BUSY;
          end
        end
        DS_BUSY: begin
          if (busy_ff == '0) begin
            wait_n_ff <= 1'b1;
            state_ff <= DS_DONE;
          end else begin
            busy_ff <= busy_ff - 1'b1;
          end
        end
        // wait for the strobe to end before taking another cycle
        DS_DONE: if (!active) state_ff <= DS_IDLE;
        default: state_ff <= DS_IDLE;
      endcase
    end
  end

  // read data is driven from wait release until the read access ends
  always_ff @(posedge mclk_in) begin
    if (rst_in || ctrl_reset_out) begin
      bus.db_dev_o <= 16'h0000;
      bus.db_dev_oe_n <= 1'b1;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= (state_ff == DS_IDLE) && active && is_read && bus.cmd_data_select;
      if (state_ff == DS_BUSY && busy_ff == '0 && cyc_read_ff) begin
        // narrow bus returns the low byte with the upper lanes zero
        bus.db_dev_o <= wide_bus_out ? rd_word : {8'h00, rd_word[7:0]};
        bus.db_dev_oe_n <= 1'b0;
      end else if (!active) begin
        bus.db_dev_oe_n <= 1'b1;
      end
    end
  end

  // writes are taken on wait release; register 01h bit0 sets the width
  always_ff @(posedge mclk_in) begin
    if (rst_in || ctrl_reset_out) begin
      wr_valid_out <= 1'b0;
      wr_is_data_out <= 1'b0;
      wr_data_out <= 16'h0000;
      cmd_ff <= 16'h0000;
      wide_bus_out <= 1'b0;
    end else begin
      wr_valid_out <= (state_ff == DS_BUSY) && (busy_ff == '0) && !cyc_read_ff;
      if ((state_ff == DS_BUSY) && (busy_ff == '0) && !cyc_read_ff) begin
        wr_is_data_out <= cyc_data_ff;
        // narrow bus keeps only the low byte
        wr_data_out <= wide_bus_out ? bus.db : {8'h00, bus.db[7:0]};
        if (!cyc_data_ff) begin
          cmd_ff <= wide_bus_out ? bus.db : {8'h00, bus.db[7:0]};
        end else if (cmd_ff == `HPP_WIDTH_REG_ADDR) begin
          wide_bus_out <= bus.db[`HPP_WIDTH_BIT];
        end
      end
    end
  end

  // serial modes expose the control pins as inputs; parallel modes and reset read all ones
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aux_input_pins_out <= 4'hf;
    end else if (!parallel) begin
      aux_input_pins_out <= {bus.cmd_data_select, bus.wr_pin, bus.rd_pin, bus.cs_n};
    end else begin
      aux_input_pins_out <= 4'hf;
    end
  end
endmodule

// File: hpp_cfg.svh
// constants for the host parallel port: timing, widths, status value and width register
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH
`define HPP_RESET_HOLD_CYCLES 256
`define HPP_RESET_CNT_W 9
`define HPP_BUSY_CYCLES 4
`define HPP_BUSY_CNT_W 3
`define HPP_DATA_W 16
`define HPP_STATUS_VALUE 16'h0000
`define HPP_WIDTH_REG_ADDR 16'h0001
`define HPP_WIDTH_BIT 0
`endif

// File: hpp_pkg.sv
// types shared by both ends of the host parallel port
package hpp_pkg;
  typedef enum logic [2:0] {
    HPP_MODE_8080,
    HPP_MODE_6800,
    HPP_MODE_SPI3,
    HPP_MODE_SPI4,
    HPP_MODE_I2C
  } hpp_mode_t;

  typedef enum logic [1:0] {
    HPP_CYC_CMD_WR,
    HPP_CYC_DATA_WR,
    HPP_CYC_STAT_RD,
    HPP_CYC_DATA_RD
  } hpp_cyc_t;

  // strap decode, most significant strap first
  function automatic hpp_mode_t hpp_decode(input logic [2:0] sel);
    hpp_mode_t m;
    m = HPP_MODE_8080;
    case (sel[2:1])
      2'b00: m = HPP_MODE_8080;
      2'b01: m = HPP_MODE_6800;
      2'b10: m = sel[0] ? HPP_MODE_SPI4 : HPP_MODE_SPI3;
      default: m = HPP_MODE_I2C;
    endcase
    return m;
  endfunction
endpackage

// File: hpp_bus_if.sv
// parallel bus wires between the microcontroller and the display controller
`timescale 1ns/100ps
interface hpp_bus_if;
  logic [2:0] host_port_select;
  logic reset_in_n;
  logic cs_n;
  logic rd_pin;
  logic wr_pin;
  logic cmd_data_select;
  logic wait_n;
  logic [15:0] db_host_o;
  logic db_host_oe_n;
  logic [15:0] db_dev_o;
  logic db_dev_oe_n;
  logic [15:0] db;

  // resolved bus level; pulled up when nobody drives
  always_comb begin
    if (!db_dev_oe_n) begin
      db = db_dev_o;
    end else if (!db_host_oe_n) begin
      db = db_host_o;
    end else begin
      db = 16'hffff;
    end
  end

  modport dev (
    input host_port_select, reset_in_n, cs_n, rd_pin, wr_pin, cmd_data_select, db, db_host_oe_n,
    output wait_n, db_dev_o, db_dev_oe_n
  );
  modport host (
    input wait_n, db,
    output host_port_select, reset_in_n, cs_n, rd_pin, wr_pin, cmd_data_select, db_host_o, db_host_oe_n
  );
endinterface

// File: hpp_host.sv
// microcontroller end: issues 8080 or 6800 cycles and holds off on wait
`timescale 1ns/100ps
`include "hpp_cfg.svh"
module hpp_host #(
  parameter int RESET_HOLD = `HPP_RESET_HOLD_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // configuration
  input wire logic [2:0] strap_in,
  input wire logic dev_reset_req_in,
  // request
  input wire logic req_valid_in,
  input wire hpp_pkg::hpp_cyc_t req_kind_in,
  input wire logic [15:0] req_data_in,
  output logic req_ready_out,
  // answer
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  // bus
  hpp_bus_if.host bus
);
  typedef enum logic [2:0] {HS_RESET, HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD, HS_WAIT, HS_END} hpp_hst_t;
  hpp_hst_t state_ff;
  hpp_pkg::hpp_cyc_t kind_ff;
  logic [15:0] wdata_ff;
  logic [`HPP_RESET_CNT_W:0] rcnt_ff;
  logic is_6800;
  logic is_read;

  assign is_6800 = (hpp_pkg::hpp_decode(strap_in) == hpp_pkg::HPP_MODE_6800);
  assign is_read = (kind_ff == hpp_pkg::HPP_CYC_STAT_RD) || (kind_ff == hpp_pkg::HPP_CYC_DATA_RD);
  assign req_ready_out = (state_ff == HS_IDLE);
  assign bus.host_port_select = strap_in;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_ff <= HS_RESET;
      rcnt_ff <= '0;
    end else begin
      case (state_ff)
        HS_RESET: begin
          // hold the reset pin low for the full count
          rcnt_ff <= rcnt_ff + 1'b1;
          if (rcnt_ff == (`HPP_RESET_CNT_W+1)'(RESET_HOLD)) begin
            state_ff <= HS_IDLE;
          end
        end
        HS_IDLE: begin
          if (dev_reset_req_in) begin
            rcnt_ff <= '0;
            state_ff <= HS_RESET;
          end else if (req_valid_in) begin
            kind_ff <= req_kind_in;
            wdata_ff <= req_data_in;
            state_ff <= HS_SETUP;
          end
        end
        HS_SETUP: state_ff <= HS_STROBE;
        // the controller pulls wait low on the edge where it sees the strobe, so skip that edge
        HS_STROBE: state_ff <= HS_HOLD;
        HS_HOLD: state_ff <= HS_WAIT;
        // hold the strobe until the device lets wait go
        HS_WAIT: if (bus.wait_n) state_ff <= HS_END;
        HS_END: state_ff <= HS_IDLE;
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bus.reset_in_n <= 1'b0;
      bus.cs_n <= 1'b1;
      bus.rd_pin <= 1'b1;
      bus.wr_pin <= 1'b1;
      bus.cmd_data_select <= 1'b0;
      bus.db_host_o <= 16'h0000;
      bus.db_host_oe_n <= 1'b1;
    end else begin
      bus.reset_in_n <= !(state_ff == HS_RESET && !(rcnt_ff == (`HPP_RESET_CNT_W+1)'(RESET_HOLD)));
      if (state_ff == HS_SETUP) begin
        bus.cs_n <= 1'b0;
        // command/status on low, data on high
        bus.cmd_data_select <= (kind_ff == hpp_pkg::HPP_CYC_DATA_WR) || (kind_ff == hpp_pkg::HPP_CYC_DATA_RD);
        bus.db_host_o <= wdata_ff;
        bus.db_host_oe_n <= is_read;
        if (is_6800) begin
          bus.wr_pin <= is_read; // direction high reads, low writes
          bus.rd_pin <= 1'b0;
        end else begin
          bus.wr_pin <= 1'b1;
          bus.rd_pin <= 1'b1;
        end
      end else if (state_ff == HS_STROBE) begin
        if (is_6800) begin
          bus.rd_pin <= 1'b1; // enable qualifier high
        end else if (is_read) begin
          bus.rd_pin <= 1'b0;
        end else begin
          bus.wr_pin <= 1'b0;
        end
      end else if (state_ff == HS_END) begin
        bus.cs_n <= 1'b1;
        bus.rd_pin <= !is_6800;
        bus.wr_pin <= 1'b1;
        bus.db_host_oe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
    end else begin
      rsp_valid_out <= (state_ff == HS_WAIT) && bus.wait_n && is_read;
      if ((state_ff == HS_WAIT) && bus.wait_n && is_read) begin
        rsp_data_out <= bus.db;
      end
    end
  end
endmodule

// File: hpp_bus_chk.sv
// checks on the wires between host and controller
`timescale 1ns/100ps
module hpp_bus_chk (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // bus wires
  input wire logic [2:0] host_port_select,
  input wire logic cs_n,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic wait_n,
  input wire logic db_dev_oe_n
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  wire logic m80 = host_port_select[2:1] == 2'b00;
  wire logic m68 = host_port_select[2:1] == 2'b01;
  // busy figure fixed at the default of four cycles plus one
  sequence s_busy;
    !wait_n [*5] ##1 wait_n;
  endsequence
  a_wait_on_strobe: assert property (!cs_n && m80 && ($fell(rd_pin) || $fell(wr_pin)) |=> !wait_n)
    else $error("no wait on strobe");
  a_wait_on_enable: assert property (!cs_n && m68 && $rose(rd_pin) |=> !wait_n)
    else $error("no wait on enable");
  a_busy_length: assert property ($fell(wait_n) |-> s_busy)
    else $error("wait length");
  a_wait_needs_cs: assert property (!wait_n |-> !cs_n)
    else $error("wait unselected");
  a_serial_no_wait: assert property (host_port_select[2] && $past(host_port_select[2]) |-> wait_n)
    else $error("wait in serial");
  a_read_8080_drive: assert property (m80 && $rose(wait_n) && !rd_pin |-> !db_dev_oe_n)
    else $error("read undriven");
  a_read_6800_drive: assert property (m68 && $rose(wait_n) && rd_pin && wr_pin |-> !db_dev_oe_n)
    else $error("read undriven");
  a_write_no_drive: assert property (!wr_pin && (m80 || m68 && rd_pin) |-> db_dev_oe_n)
    else $error("driven on write");
endmodule

// File: host_parallel_port_tb.sv
// bench joining the host and controller ends of the parallel port
`timescale 1ns/100ps
`define HPP_CHECK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t %h %h", $time, (a), (e)); end end
module host_parallel_port_tb;
  localparam int HOLD = 8;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] strap = 3'h0;
  logic rreq = 1'b0;
  logic req_valid = 1'b0;
  hpp_pkg::hpp_cyc_t req_kind = hpp_pkg::HPP_CYC_CMD_WR;
  logic [15:0] req_data = 16'h0000;
  logic [15:0] rd_data = 16'h0000;
  logic [15:0] status = 16'h0000;
  logic req_ready, rsp_valid, wr_valid, wr_is_data, rd_valid, ctrl_reset, wide;
  logic [15:0] rsp_data, wr_data;
  logic [3:0] aux;
  hpp_pkg::hpp_mode_t mode;
  int seed = 13;
  int fail_count = 0;
  int checked = 0;
  int low_cnt = 0;
  logic wide_exp = 1'b0;
  logic [15:0] last_cmd = 16'h0000;
  hpp_bus_if u_hpp_bus_if ();
  hpp_host #(.RESET_HOLD(HOLD)) u_hpp_host (.mclk_in(mclk_in), .rst_in(rst_in), .strap_in(strap),
    .dev_reset_req_in(rreq), .req_valid_in(req_valid), .req_kind_in(req_kind), .req_data_in(req_data),
    .req_ready_out(req_ready), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .bus(u_hpp_bus_if));
  hpp_device #(.RESET_HOLD(HOLD), .BUSY_CYCLES(4)) u_hpp_device (.mclk_in(mclk_in), .rst_in(rst_in),
    .bus(u_hpp_bus_if), .rd_data_in(rd_data), .status_in(status), .wr_valid_out(wr_valid),
    .wr_is_data_out(wr_is_data), .wr_data_out(wr_data), .rd_valid_out(rd_valid), .ctrl_reset_out(ctrl_reset),
    .wide_bus_out(wide), .mode_out(mode), .aux_input_pins_out(aux));
  hpp_bus_chk u_hpp_bus_chk (.mclk_in(mclk_in), .rst_in(rst_in), .host_port_select(u_hpp_bus_if.host_port_select),
    .cs_n(u_hpp_bus_if.cs_n), .rd_pin(u_hpp_bus_if.rd_pin), .wr_pin(u_hpp_bus_if.wr_pin),
    .wait_n(u_hpp_bus_if.wait_n), .db_dev_oe_n(u_hpp_bus_if.db_dev_oe_n));
  initial forever #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    low_cnt <= u_hpp_bus_if.reset_in_n ? 0 : low_cnt + 1;
  end
  function automatic logic pick(input int w);
    case (w)
      0: return req_ready;
      1: return rsp_valid;
      2: return wr_valid;
      3: return ctrl_reset;
      default: return !ctrl_reset;
    endcase
  endfunction
  function automatic hpp_pkg::hpp_mode_t exp_mode(input logic [2:0] s);
    case (s[2:1])
      2'b00: return hpp_pkg::HPP_MODE_8080;
      2'b01: return hpp_pkg::HPP_MODE_6800;
      2'b10: return s[0] ? hpp_pkg::HPP_MODE_SPI4 : hpp_pkg::HPP_MODE_SPI3;
      default: return hpp_pkg::HPP_MODE_I2C;
    endcase
  endfunction
  // narrow bus carries the low byte only
  function automatic logic [15:0] exp_bus(input logic [15:0] d);
    return wide_exp ? d : {8'h00, d[7:0]};
  endfunction
  task automatic give_verdict();
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_hi(input int w);
    int i;
    for (i = 0; i < 400 && pick(w) !== 1'b1; i++) @(negedge mclk_in);
    if (i >= 400) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic xfer(input hpp_pkg::hpp_cyc_t k, input logic [15:0] d);
    logic [15:0] r;
    r = 16'($random(seed));
    wait_hi(0);
    @(posedge mclk_in);
    req_valid <= 1'b1;
    req_kind <= k;
    req_data <= d;
    rd_data <= r;
    status <= ~r;
    @(posedge mclk_in);
    req_valid <= 1'b0;
    if (k inside {hpp_pkg::HPP_CYC_STAT_RD, hpp_pkg::HPP_CYC_DATA_RD}) begin
      wait_hi(1);
      `HPP_CHECK(rsp_data, exp_bus(k == hpp_pkg::HPP_CYC_DATA_RD ? r : ~r))
    end else begin
      wait_hi(2);
      `HPP_CHECK(wr_data, exp_bus(d))
      `HPP_CHECK(wr_is_data, k == hpp_pkg::HPP_CYC_DATA_WR)
      if (k == hpp_pkg::HPP_CYC_CMD_WR) last_cmd = exp_bus(d);
      else if (last_cmd == 16'h0001) wide_exp = d[0];
      @(negedge mclk_in);
      `HPP_CHECK(wide, wide_exp)
    end
  endtask
  initial begin
    int n;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    `HPP_CHECK(ctrl_reset, 1'b1)
    wait_hi(4);
    for (n = 0; n < 8; n++) begin
      @(posedge mclk_in);
      strap <= n[2:0];
      repeat (2) @(negedge mclk_in);
      `HPP_CHECK(mode, exp_mode(n[2:0]))
      `HPP_CHECK(aux, (n[2] ? {u_hpp_bus_if.cmd_data_select, u_hpp_bus_if.wr_pin, u_hpp_bus_if.rd_pin, u_hpp_bus_if.cs_n} : 4'hf))
    end
    for (n = 0; n < 48; n++) begin
      if (n % 12 == 0) begin
        @(posedge mclk_in);
        strap <= 3'(n / 12);
        // width flips in both 8080 and both 6800 strap codes, with stray upper bits on the write
        xfer(hpp_pkg::HPP_CYC_CMD_WR, 16'h0001);
        xfer(hpp_pkg::HPP_CYC_DATA_WR, (n % 24 == 0) ? 16'hab01 : 16'hfffe);
      end
      xfer(hpp_pkg::hpp_cyc_t'(2'($random(seed))), 16'($random(seed)));
    end
    @(posedge mclk_in);
    rreq <= 1'b1;
    @(posedge mclk_in);
    rreq <= 1'b0;
    repeat (3) @(negedge mclk_in);
    `HPP_CHECK(ctrl_reset, 1'b0)
    wait_hi(3);
    `HPP_CHECK(low_cnt >= HOLD, 1'b1)
    wait_hi(4);
    give_verdict();
  end
endmodule
